// [pkg/fcsf_consts.vh]
// constants for the flash command status flag block
`ifndef FCSF_CONSTS_VH
`define FCSF_CONSTS_VH
// ****************************************
// register map
// ****************************************
`define FCSF_ADDR_W 4
`define FCSF_OFS_STATUS 4'h6
`define FCSF_OFS_EVENTS 4'h0
// ****************************************
// status field positions
// ****************************************
`define FCSF_BIT_DONE 7
`define FCSF_BIT_RSV6 6
`define FCSF_BIT_ACC 5
`define FCSF_BIT_PROT 4
`define FCSF_BIT_BUSY 3
`define FCSF_BIT_RSV2 2
`define FCSF_ERR_HI 1
`define FCSF_ERR_LO 0
`define FCSF_ERR_W 2
// ****************************************
// reset values
// ****************************************
`define FCSF_RST_STATUS 8'h80
`define FCSF_RST_ERR 2'h0
`endif

// [hdl/fcsf_error_capture.v]
// command error status capture for the flash command status block
`timescale 1ns/1ps
// ****************************************
// error status field: hardware set, cleared at each launch
// ****************************************
module fcsf_error_capture (
   // clock and reset
   input wire mclk,
   input wire srst,
   // events
   input wire launch,
   input wire [1:0] errSet,
   input wire [1:0] resetSeqErr,
   input wire resetSeqDone,
   // status
   output wire [1:0] errStatus
);
   reg [1:0] err_ff; // captured error bits
   reg [1:0] nxt_err;
   // next error value: a new launch clears, any error event sets
   always @* begin
      nxt_err = err_ff;
      if (launch) begin
         nxt_err = 2'h0;
      end
      nxt_err = nxt_err | errSet;
      if (resetSeqDone) begin
         nxt_err = nxt_err | resetSeqErr;
      end
   end
   // error register
   always @(posedge mclk) begin
      if (srst) begin
         err_ff <= 2'h0;
      end else begin
         err_ff <= nxt_err;
      end
   end
   assign errStatus = err_ff;
endmodule // fcsf_error_capture

// [hdl/fcsf_status_flags.v]
// flash command status flags with register port and command handshake
`timescale 1ns/1ps
`include "fcsf_consts.vh"
// ****************************************
// top module
// ****************************************
module fcsf_status_flags (
   // clock and reset
   input wire mclk,
   input wire srst,
   // register port
   input wire [3:0] regAddr,
   input wire [7:0] regWdata,
   input wire regWr,
   input wire regRd,
   output reg [7:0] regRdata,
   // command sequencer side
   input wire seqWrite,
   input wire accessViolation,
   input wire protViolation,
   input wire cmdDone,
   input wire [1:0] cmdErr,
   output wire cmdLaunch,
   output wire seqAllowed,
   output wire cmdBusy,
   // reset sequence
   input wire resetSeqDone,
   input wire [1:0] resetSeqErr
);
   // ****************************************
   // state
   // ****************************************
   reg cmdCmpl_ff; // command complete flag
   reg acc_ff; // access error flag
   reg prot_ff; // protection violation flag
   reg busy_ff; // controller busy
   reg nxt_cmdCmpl;
   reg nxt_acc;
   reg nxt_prot;
   reg nxt_busy;
   wire [1:0] errStatus; // command error status field
   wire statusWr; // write aimed at status register
   wire launchReq; // software asks for launch
   wire [7:0] statusVal; // assembled status byte
   // address match used by write and read paths
   function hitStatus;
      input [3:0] a;
      begin
         hitStatus = (a == `FCSF_OFS_STATUS);
      end
   endfunction
   assign statusWr = regWr & hitStatus(regAddr);
   assign launchReq = statusWr & regWdata[`FCSF_BIT_DONE] & cmdCmpl_ff;
   // launch only when neither error flag is pending
   assign cmdLaunch = launchReq & ~acc_ff & ~prot_ff;
   // a new command write sequence may begin only while no protection violation is flagged and idle
   assign seqAllowed = ~prot_ff & cmdCmpl_ff;
   assign cmdBusy = busy_ff;
   // ****************************************
   // flag update
   // ****************************************
   // next flag values; hardware set wins over software clear
   always @* begin
      nxt_cmdCmpl = cmdCmpl_ff;
      nxt_acc = acc_ff;
      nxt_prot = prot_ff;
      nxt_busy = busy_ff;
      // write-one-to-clear of the error flags
      if (statusWr & regWdata[`FCSF_BIT_ACC]) begin
         nxt_acc = 1'b0;
      end
      if (statusWr & regWdata[`FCSF_BIT_PROT]) begin
         nxt_prot = 1'b0;
      end
      // a launch drops the complete flag until done
      if (cmdLaunch) begin
         nxt_cmdCmpl = 1'b0;
         nxt_busy = 1'b1;
      end else if (!cmdCmpl_ff && cmdDone) begin
         nxt_cmdCmpl = 1'b1;
         nxt_busy = 1'b0;
      end
      // hardware events set the flags
      if (accessViolation || (launchReq && prot_ff)) begin
         nxt_acc = 1'b1;
      end
      if (protViolation && seqWrite) begin
         nxt_prot = 1'b1;
      end
   end
   // flag registers
   always @(posedge mclk) begin
      if (srst) begin
         cmdCmpl_ff <= 1'b1;
         acc_ff <= 1'b0;
         prot_ff <= 1'b0;
         busy_ff <= 1'b0;
      end else begin
         cmdCmpl_ff <= nxt_cmdCmpl;
         acc_ff <= nxt_acc;
         prot_ff <= nxt_prot;
         busy_ff <= nxt_busy;
      end
   end
   // ****************************************
   // error status field
   // ****************************************
   fcsf_error_capture uErr (
      .mclk(mclk),
      .srst(srst),
      .launch(cmdLaunch),
      .errSet(cmdDone & ~cmdCmpl_ff ? cmdErr : 2'h0),
      .resetSeqErr(resetSeqErr),
      .resetSeqDone(resetSeqDone),
      .errStatus(errStatus)
   );
   // ****************************************
   // read path
   // ****************************************
   // status byte; bits 6 and 2 are constant zero
   assign statusVal = {cmdCmpl_ff, 1'b0, acc_ff, prot_ff, busy_ff, 1'b0, errStatus};
   // read data registered, valid the cycle after the strobe only
   always @(posedge mclk) begin
      if (srst) begin
         regRdata <= 8'h00;
      end else if (regRd && hitStatus(regAddr)) begin
         regRdata <= statusVal;
      end else begin
         regRdata <= 8'h00;
      end
   end
endmodule // fcsf_status_flags

// [testbench/fcsf_chk_sva.sv]
// checker on the ports of the flash command status flags
`timescale 1ns/1ps
module fcsf_chk (
   // clock and reset
   input wire mclk, srst,
   // register port
   input wire [3:0] regAddr,
   input wire [7:0] regWdata, regRdata,
   input wire regWr, regRd,
   // sequencer side
   input wire seqWrite, protViolation, cmdDone, cmdLaunch, seqAllowed, cmdBusy
);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   property p_launchWr; cmdLaunch |-> regWr && regAddr == 4'h6 && regWdata[7]; endproperty
   a_launchWr: assert property (p_launchWr) else $error("launch without write");
   property p_launchOk; cmdLaunch |-> seqAllowed; endproperty
   a_launchOk: assert property (p_launchOk) else $error("launch while blocked");
   property p_busyUp; cmdLaunch |=> cmdBusy; endproperty
   a_busyUp: assert property (p_busyUp) else $error("busy not set");
   property p_busyDn; cmdBusy && cmdDone |=> !cmdBusy; endproperty
   a_busyDn: assert property (p_busyDn) else $error("busy not cleared");
   property p_busySeq; cmdBusy |-> !seqAllowed; endproperty
   a_busySeq: assert property (p_busySeq) else $error("complete while busy");
   property p_prot; seqWrite && protViolation |=> !seqAllowed; endproperty
   a_prot: assert property (p_prot) else $error("protection not set");
   property p_rsv; regRd |=> !regRdata[2]; endproperty
   a_rsv: assert property (p_rsv) else $error("bit 2 not zero");
   property p_rdBusy; regRd && regAddr == 4'h6 |=> regRdata[3] == $past(cmdBusy); endproperty
   a_rdBusy: assert property (p_rdBusy) else $error("busy bit mismatch");
endmodule // fcsf_chk
bind fcsf_status_flags fcsf_chk u_chk (.*);

// [testbench/test_fcsf_status_flags.sv]
// testbench for the flash command status flags
`timescale 1ns/1ps
module test_fcsf_status_flags;
   reg mclk = 0, srst = 1, regWr = 0, regRd = 0, seqWrite = 0, accessViolation = 0;
   reg protViolation = 0, cmdDone = 0, resetSeqDone = 0;
   reg [3:0] regAddr = 4'h0;
   reg [7:0] regWdata = 8'h00;
   reg [1:0] cmdErr = 2'h0, resetSeqErr = 2'h0;
   wire [7:0] regRdata;
   wire cmdLaunch, seqAllowed, cmdBusy;
   integer fails = 0, samples_checked = 0;
   always #2 mclk = ~mclk;
   fcsf_status_flags dut (.*);
   // compare one value
   task chk(input [63:0] nm, input [7:0] s, input [7:0] e);
      begin
         samples_checked = samples_checked + 1;
         if (s !== e) begin
            fails = fails + 1;
            $display("Error %0s expected %h seen %h", nm, e, s);
         end
      end
   endtask
   // one-cycle status write, launch pulse checked in that cycle
   task wr(input [7:0] d, input l);
      begin
         @(posedge mclk);
         regWr <= 1'b1;
         regAddr <= 4'h6;
         regWdata <= d;
         #1 chk("launch", {7'h0, cmdLaunch}, {7'h0, l});
         @(posedge mclk);
         regWr <= 1'b0;
      end
   endtask
   // one-cycle read, data taken in the following cycle
   task rd(input [3:0] a, input [7:0] e);
      begin
         @(posedge mclk);
         regRd <= 1'b1;
         regAddr <= a;
         @(posedge mclk);
         regRd <= 1'b0;
         #1 chk("rdata", regRdata, e);
      end
   endtask
   task end_sim;
      begin
         $display("checks %0d mismatches %0d", samples_checked, fails);
         if (fails == 0 && samples_checked > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   initial begin
      #4000;
      fails = fails + 1;
      end_sim;
   end
   initial begin
      repeat (16) @(posedge mclk);
      srst <= 1'b0;
      rd(4'h6, 8'h80);
      wr(8'h80, 1'b1);
      rd(4'h6, 8'h08);
      @(posedge mclk) cmdDone <= 1'b1;
      cmdErr <= 2'h3;
      @(posedge mclk) cmdDone <= 1'b0;
      rd(4'h6, 8'h83);
      wr(8'h0f, 1'b0);
      rd(4'h6, 8'h83);
      $display("test launch done");
      seqWrite <= 1'b1;
      protViolation <= 1'b1;
      @(posedge mclk) protViolation <= 1'b0;
      seqWrite <= 1'b0;
      rd(4'h6, 8'h93);
      chk("seqok", {7'h0, seqAllowed}, 8'h00);
      wr(8'h80, 1'b0);
      rd(4'h6, 8'hb3);
      wr(8'h00, 1'b0);
      rd(4'h6, 8'hb3);
      wr(8'h10, 1'b0);
      wr(8'h80, 1'b0);
      rd(4'h6, 8'ha3);
      wr(8'h20, 1'b0);
      $display("test protection done");
      wr(8'h80, 1'b1);
      cmdErr <= 2'h0;
      @(posedge mclk) cmdDone <= 1'b1;
      @(posedge mclk) cmdDone <= 1'b0;
      rd(4'h6, 8'h80);
      resetSeqDone <= 1'b1;
      resetSeqErr <= 2'h1;
      @(posedge mclk) resetSeqDone <= 1'b0;
      rd(4'h6, 8'h81);
      rd(4'h0, 8'h00);
      @(posedge mclk) accessViolation <= 1'b1;
      @(posedge mclk) accessViolation <= 1'b0;
      rd(4'h6, 8'ha1);
      wr(8'h20, 1'b0);
      rd(4'h6, 8'h81);
      $display("test reset errors done");
      end_sim;
   end
endmodule // test_fcsf_status_flags
